// >>> src/pierc_top.sv
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module pierc_top (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // axi4-lite slave
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // dwords arriving from the switch core
  input  wire logic        rx_valid,
  input  wire logic [31:0] rx_data,
  input  wire logic [3:0]  rx_par,
  // dwords going to the switch core
  input  wire logic        tx_in_valid,
  input  wire logic        tx_in_sop,
  input  wire logic        tx_in_eop,
  input  wire logic [31:0] tx_in_data,
  output logic             tx_valid,
  output logic             tx_sop,
  output logic             tx_eop,
  output logic [31:0]      tx_data,
  output logic [3:0]       tx_par,
  // error reporting
  input  wire logic        upstream_irq_enable,
  output logic             err_msg_valid,
  output logic [1:0]       err_msg_sev,
  output logic             irq_req,
  // input queue time-out
  input  wire logic        queue_tlp_expired,
  output logic             queue_discard,
  output logic             queue_timeout_enable
);

  logic        rst_meta_ff, rst_n_ff;
  logic        aw_rdy_ff, w_rdy_ff, bvalid_ff, ar_rdy_ff, rvalid_ff;
  logic [11:0] waddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0]  wstrb_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic        parity_check_disable_ff, bad_parity_inject_ff;
  logic [7:0]  match_len_ff;
  logic        parity_error_flag_ff, parity_error_irq_enable_ff;
  logic [1:0]  report_sev_ff;
  logic [7:0]  parity_error_tally_ff;
  logic        queue_timeout_enable_ff;
  logic        inj_tlp_ff;
  logic        tx_valid_ff, tx_sop_ff, tx_eop_ff;
  logic [31:0] tx_data_ff;
  logic [3:0]  tx_par_ff;
  logic        err_msg_valid_ff, irq_req_ff, queue_discard_ff;
  logic [1:0]  err_msg_sev_ff;
  logic        wr_go, rd_go, wr_hit_sts, rd_clr, det, hdr_match, cur_bad;
  logic [31:0] nxt_rdata;
  logic [1:0]  nxt_rresp;

  pierc_par_if chk_if ();
  pierc_par_if gen_if ();

  pierc_parity u_chk (.p(chk_if.calc));
  pierc_parity u_gen (.p(gen_if.calc));

  assign chk_if.data = rx_data;
  assign gen_if.data = tx_in_data;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  // bus strobes and parity error detection
  assign wr_go      = !aw_rdy_ff && !w_rdy_ff && !bvalid_ff;
  assign rd_go      = s_axi_arvalid && ar_rdy_ff;
  assign wr_hit_sts = wr_go && waddr_ff == pierc_pkg::OFS_ERR_STS && wstrb_ff[0];
  assign rd_clr     = rd_go && s_axi_araddr[11:0] == pierc_pkg::OFS_ERR_CNT;
  assign det = rx_valid && !parity_check_disable_ff && chk_if.par != rx_par;

  // write channel: take address and data in any order, answer after both
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      aw_rdy_ff <= 1'b1;
      w_rdy_ff  <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff  <= pierc_pkg::RESP_OKAY;
      waddr_ff  <= 12'h000;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid && aw_rdy_ff) begin
        aw_rdy_ff <= 1'b0;
        waddr_ff  <= s_axi_awaddr[11:0];
      end
      if (s_axi_wvalid && w_rdy_ff) begin
        w_rdy_ff <= 1'b0;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        unique case (waddr_ff)
          pierc_pkg::OFS_PAR_CTL, pierc_pkg::OFS_ERR_STS, pierc_pkg::OFS_ERR_REP,
          pierc_pkg::OFS_ERR_CNT, pierc_pkg::OFS_TO_CTL: bresp_ff <= pierc_pkg::RESP_OKAY;
          default: bresp_ff <= pierc_pkg::RESP_SLVERR;
        endcase
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        aw_rdy_ff <= 1'b1;
        w_rdy_ff  <= 1'b1;
      end
    end
  end

  // control registers, byte lanes honoured
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      parity_check_disable_ff    <= pierc_pkg::RST_DIS;
      bad_parity_inject_ff       <= pierc_pkg::RST_INJ;
      match_len_ff               <= pierc_pkg::RST_LEN;
      report_sev_ff              <= pierc_pkg::RST_SEV;
      parity_error_irq_enable_ff <= pierc_pkg::RST_IRQ;
      queue_timeout_enable_ff    <= pierc_pkg::RST_TO;
    end else if (wr_go) begin
      if (waddr_ff == pierc_pkg::OFS_PAR_CTL && wstrb_ff[0]) begin
        parity_check_disable_ff <= wdata_ff[pierc_pkg::DIS_BIT];
        bad_parity_inject_ff    <= wdata_ff[pierc_pkg::INJ_BIT];
      end
      if (waddr_ff == pierc_pkg::OFS_PAR_CTL && wstrb_ff[1])
        match_len_ff <= wdata_ff[pierc_pkg::LEN_LSB +: 8];
      if (waddr_ff == pierc_pkg::OFS_ERR_REP && wstrb_ff[0]) begin
        report_sev_ff              <= wdata_ff[pierc_pkg::SEV_LSB +: 2];
        parity_error_irq_enable_ff <= wdata_ff[pierc_pkg::IRQ_BIT];
      end
      if (waddr_ff == pierc_pkg::OFS_TO_CTL && wstrb_ff[0])
        queue_timeout_enable_ff <= wdata_ff[pierc_pkg::TO_BIT];
    end
  end

  // status flag: detection wins over a same-cycle write-one clear
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff)
      parity_error_flag_ff <= pierc_pkg::RST_FLAG;
    else if (det)
      parity_error_flag_ff <= 1'b1;
    else if (wr_hit_sts && wdata_ff[pierc_pkg::FLAG_BIT])
      parity_error_flag_ff <= 1'b0;
  end

  // saturating counter, cleared by a read
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff)
      parity_error_tally_ff <= pierc_pkg::RST_CNT;
    else if (rd_clr)
      parity_error_tally_ff <= det ? pierc_pkg::CNT_ONE : pierc_pkg::RST_CNT;
    else if (det && parity_error_tally_ff != pierc_pkg::CNT_MAX)
      parity_error_tally_ff <= parity_error_tally_ff + 8'h01;
  end

  // read data mux
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = pierc_pkg::RESP_OKAY;
    unique case (s_axi_araddr[11:0])
      pierc_pkg::OFS_PAR_CTL: begin
        nxt_rdata[pierc_pkg::DIS_BIT]      = parity_check_disable_ff;
        nxt_rdata[pierc_pkg::INJ_BIT]      = bad_parity_inject_ff;
        nxt_rdata[pierc_pkg::LEN_LSB +: 8] = match_len_ff;
      end
      pierc_pkg::OFS_ERR_STS: nxt_rdata[pierc_pkg::FLAG_BIT] = parity_error_flag_ff;
      pierc_pkg::OFS_ERR_REP: begin
        nxt_rdata[pierc_pkg::SEV_LSB +: 2] = report_sev_ff;
        nxt_rdata[pierc_pkg::IRQ_BIT]      = parity_error_irq_enable_ff;
      end
      pierc_pkg::OFS_ERR_CNT: nxt_rdata[7:0] = parity_error_tally_ff;
      pierc_pkg::OFS_TO_CTL:  nxt_rdata[pierc_pkg::TO_BIT] = queue_timeout_enable_ff;
      default:                nxt_rresp = pierc_pkg::RESP_SLVERR;
    endcase
  end

  // read channel
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      ar_rdy_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= pierc_pkg::RESP_OKAY;
    end else if (rd_go) begin
      ar_rdy_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end else if (rvalid_ff && s_axi_rready) begin
      ar_rdy_ff <= 1'b1;
      rvalid_ff <= 1'b0;
    end
  end

  // outgoing path: parity always generated, optionally corrupted per tlp
  assign hdr_match = tx_in_data[pierc_pkg::HDR_LEN_LSB +: 8] == match_len_ff;
  assign cur_bad   = tx_in_valid && bad_parity_inject_ff &&
                     (tx_in_sop ? hdr_match : inj_tlp_ff);
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      inj_tlp_ff  <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_sop_ff   <= 1'b0;
      tx_eop_ff   <= 1'b0;
      tx_data_ff  <= 32'h0000_0000;
      tx_par_ff   <= 4'h0;
    end else begin
      if (tx_in_valid && tx_in_sop)
        inj_tlp_ff <= hdr_match && !tx_in_eop;
      else if (tx_in_valid && tx_in_eop)
        inj_tlp_ff <= 1'b0;
      tx_valid_ff <= tx_in_valid;
      tx_sop_ff   <= tx_in_sop;
      tx_eop_ff   <= tx_in_eop;
      tx_data_ff  <= tx_in_data;
      tx_par_ff   <= gen_if.par ^ {4{cur_bad}};
    end
  end

  // error message, interrupt request and queue discard
  always_ff @(posedge sys_clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      err_msg_valid_ff <= 1'b0;
      err_msg_sev_ff   <= pierc_pkg::RST_SEV;
      irq_req_ff       <= 1'b0;
      queue_discard_ff <= 1'b0;
    end else begin
      err_msg_valid_ff <= det && !parity_error_flag_ff &&
                          report_sev_ff != pierc_pkg::PIERC_SEV_NONE;
      if (det && !parity_error_flag_ff)
        err_msg_sev_ff <= report_sev_ff;
      irq_req_ff       <= det && parity_error_irq_enable_ff && upstream_irq_enable;
      queue_discard_ff <= queue_tlp_expired && queue_timeout_enable_ff;
    end
  end

  assign s_axi_awready        = aw_rdy_ff;
  assign s_axi_wready         = w_rdy_ff;
  assign s_axi_bvalid         = bvalid_ff;
  assign s_axi_bresp          = bresp_ff;
  assign s_axi_arready        = ar_rdy_ff;
  assign s_axi_rvalid         = rvalid_ff;
  assign s_axi_rdata          = rdata_ff;
  assign s_axi_rresp          = rresp_ff;
  assign tx_valid             = tx_valid_ff;
  assign tx_sop               = tx_sop_ff;
  assign tx_eop               = tx_eop_ff;
  assign tx_data              = tx_data_ff;
  assign tx_par               = tx_par_ff;
  assign err_msg_valid        = err_msg_valid_ff;
  assign err_msg_sev          = err_msg_sev_ff;
  assign irq_req              = irq_req_ff;
  assign queue_discard        = queue_discard_ff;
  assign queue_timeout_enable = queue_timeout_enable_ff;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_ff);

  property p_no_check;
    parity_check_disable_ff && !parity_error_flag_ff && !rd_clr
      |=> !parity_error_flag_ff && $stable(parity_error_tally_ff) && !irq_req_ff;
  endproperty
  a_no_check: assert property (p_no_check) else $error("error seen with check off");
  property p_good_par;
    tx_valid_ff && !$past(cur_bad) |-> tx_par_ff == pierc_pkg::pierc_par4(tx_data_ff);
  endproperty
  a_good_par: assert property (p_good_par) else $error("outgoing parity wrong");
  property p_inject;
    tx_in_valid && tx_in_sop && bad_parity_inject_ff && hdr_match
      |=> tx_par_ff == ~pierc_pkg::pierc_par4(tx_data_ff);
  endproperty
  a_inject: assert property (p_inject) else $error("bad parity not injected");
  property p_flag_set;
    det |=> parity_error_flag_ff ##1 parity_error_flag_ff || $past(wr_hit_sts);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on error");
  property p_msg_sev;
    err_msg_valid_ff |-> err_msg_sev_ff == $past(report_sev_ff) && err_msg_sev_ff != 2'h0;
  endproperty
  a_msg_sev: assert property (p_msg_sev) else $error("report severity wrong");
  property p_msg_edge;
    err_msg_valid_ff |-> $rose(parity_error_flag_ff);
  endproperty
  a_msg_edge: assert property (p_msg_edge) else $error("report without flag rise");
  property p_irq;
    det && parity_error_irq_enable_ff && upstream_irq_enable |=> irq_req_ff;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not requested");
  property p_sat;
    det && !rd_clr && parity_error_tally_ff == 8'hff |=> parity_error_tally_ff == 8'hff;
  endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped");
  property p_rd_clr;
    rd_clr && !det |=> parity_error_tally_ff == 8'h00 && rvalid_ff;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("counter not cleared by read");
  property p_rd_err;
    rd_clr && det |=> parity_error_tally_ff == 8'h01;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("error lost on read");
  property p_discard;
    queue_tlp_expired |=> queue_discard_ff == $past(queue_timeout_enable_ff);
  endproperty
  a_discard: assert property (p_discard) else $error("discard wrong");

  c_write: cover property (bvalid_ff && s_axi_bready);
  c_msg:   cover property (err_msg_valid_ff);
  c_inj:   cover property (tx_valid_ff && tx_par_ff != pierc_pkg::pierc_par4(tx_data_ff));
  c_rdclr: cover property (rd_clr && parity_error_tally_ff != 8'h00);

endmodule : pierc_top

// >>> src/pierc_pkg.sv
package pierc_pkg;

  // register byte addresses (low address bits decoded)
  localparam int unsigned    ADDR_W          = 12;
  localparam logic [11:0]    OFS_PAR_CTL     = 12'h4d4;
  localparam logic [11:0]    OFS_ERR_STS     = 12'h4d8;
  localparam logic [11:0]    OFS_ERR_REP     = 12'h4dc;
  localparam logic [11:0]    OFS_ERR_CNT     = 12'h4e0;
  localparam logic [11:0]    OFS_TO_CTL      = 12'h4e4;

  // field positions
  localparam int unsigned    DIS_BIT         = 0;
  localparam int unsigned    INJ_BIT         = 1;
  localparam int unsigned    LEN_LSB         = 8;
  localparam int unsigned    FLAG_BIT        = 0;
  localparam int unsigned    SEV_LSB         = 0;
  localparam int unsigned    IRQ_BIT         = 2;
  localparam int unsigned    TO_BIT          = 0;
  localparam int unsigned    HDR_LEN_LSB     = 24;

  // values after reset, and counter limit and step
  localparam logic           RST_DIS         = 1'h0;
  localparam logic           RST_INJ         = 1'h0;
  localparam logic [7:0]     RST_LEN         = 8'h00;
  localparam logic           RST_FLAG        = 1'h0;
  localparam logic [1:0]     RST_SEV         = 2'h2;
  localparam logic           RST_IRQ         = 1'h0;
  localparam logic [7:0]     RST_CNT         = 8'h00;
  localparam logic           RST_TO          = 1'h1;
  localparam logic [7:0]     CNT_MAX         = 8'hff;
  localparam logic [7:0]     CNT_ONE         = 8'h01;

  // bus response codes
  localparam logic [1:0]     RESP_OKAY       = 2'h0;
  localparam logic [1:0]     RESP_SLVERR     = 2'h2;

  // error report severity
  typedef enum logic [1:0] {
    PIERC_SEV_NONE,
    PIERC_SEV_COR,
    PIERC_SEV_NONFATAL,
    PIERC_SEV_FATAL
  } pierc_sev_e;

  // even parity, one bit per byte
  function automatic logic [3:0] pierc_par4(input logic [31:0] d);
    pierc_par4 = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction : pierc_par4

endpackage : pierc_pkg

// >>> src/pierc_par_if.sv
`timescale 1ns/1ps
interface pierc_par_if;
  logic [31:0] data;
  logic [3:0]  par;
  modport calc (input data, output par);
  modport user (output data, input par);
endinterface : pierc_par_if

// >>> src/pierc_parity.sv
`timescale 1ns/1ps
module pierc_parity (
  pierc_par_if.calc p
);
  // one even parity bit per byte lane
  genvar g;
  for (g = 0; g < 4; g++) begin : g_lane
    assign p.par[g] = ^p.data[8*g +: 8];
  end
endmodule : pierc_parity

// >>> tb/pierc_core_model.sv
`timescale 1ns/1ps
module pierc_core_model (
  input  wire logic        clk,
  output logic             rx_valid,
  output logic [31:0]      rx_data,
  output logic [3:0]       rx_par,
  output logic             tx_in_valid,
  output logic             tx_in_sop,
  output logic             tx_in_eop,
  output logic [31:0]      tx_in_data
);
  // even parity, one bit per byte
  function automatic logic [3:0] ep(input logic [31:0] d);
    ep = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction : ep

  // idle levels at time zero
  initial begin
    rx_valid    = 1'b0;
    rx_data     = 32'h0;
    rx_par      = 4'h0;
    tx_in_valid = 1'b0;
    tx_in_sop   = 1'b0;
    tx_in_eop   = 1'b0;
    tx_in_data  = 32'h0;
  end

  // n dwords back to back, parity spoiled when bad
  task automatic send_rx(input int n, input logic bad);
    logic [31:0] d;
    for (int i = 0; i < n; i++) begin
      d = 32'h5a00_0000 ^ 32'(i * 7);
      rx_valid <= 1'b1;
      rx_data  <= d;
      rx_par   <= bad ? ~ep(d) : ep(d);
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~d;  // released bus carries junk
    rx_par   <= ~rx_par;
  endtask : send_rx

  // one tlp of n dwords, length byte in the header dword
  task automatic send_tlp(input logic [7:0] len, input int n);
    logic [31:0] d;
    for (int i = 0; i < n; i++) begin
      d = (i == 0) ? {len, 24'h00_0a01} : 32'h3c00_0000 + 32'(i);
      tx_in_valid <= 1'b1;
      tx_in_sop   <= (i == 0);
      tx_in_eop   <= (i == n - 1);
      tx_in_data  <= d;
      @(posedge clk);
    end
    tx_in_valid <= 1'b0;
    tx_in_sop   <= 1'b0;
    tx_in_eop   <= 1'b0;
    tx_in_data  <= ~d;
  endtask : send_tlp
endmodule : pierc_core_model

// >>> tb/pierc_top_tb.sv
`timescale 1ns/1ps
module pierc_top_tb;
  logic        clk = 1'b0, reset_n = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r, err_msg_sev, last_sev;
  logic        rx_valid, tx_in_valid, tx_in_sop, tx_in_eop, tx_valid, tx_sop, tx_eop;
  logic [31:0] rx_data, tx_in_data, tx_data;
  logic [3:0]  rx_par, tx_par;
  logic        up_irq = 1'b0, expired = 1'b0, err_msg_valid, irq_req, queue_discard, to_en;
  logic        exp_inj = 1'b0, bad_pkt = 1'b0;
  logic [7:0]  exp_len = 8'h0;
  logic [3:0]  strb = 4'hf;
  int          err_total = 0, compares = 0, n_msg = 0, n_irq = 0, n_disc = 0, n_tx = 0, m, q;
  int          n_eop = 0;

  // 200 mhz clock
  always #2.5 clk = ~clk;

  pierc_top i_pierc_top (
    .sys_clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_par(rx_par),
    .tx_in_valid(tx_in_valid), .tx_in_sop(tx_in_sop), .tx_in_eop(tx_in_eop),
    .tx_in_data(tx_in_data), .tx_valid(tx_valid), .tx_sop(tx_sop), .tx_eop(tx_eop),
    .tx_data(tx_data), .tx_par(tx_par), .upstream_irq_enable(up_irq),
    .err_msg_valid(err_msg_valid), .err_msg_sev(err_msg_sev), .irq_req(irq_req),
    .queue_tlp_expired(expired), .queue_discard(queue_discard), .queue_timeout_enable(to_en)
  );

  pierc_core_model i_pierc_core_model (
    .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_par(rx_par),
    .tx_in_valid(tx_in_valid), .tx_in_sop(tx_in_sop), .tx_in_eop(tx_in_eop),
    .tx_in_data(tx_in_data)
  );

  // reference parity, one bit per byte
  function automatic logic [3:0] ep(input logic [31:0] x);
    ep = {^x[31:24], ^x[23:16], ^x[15:8], ^x[7:0]};
  endfunction : ep

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask : chk

  task automatic results;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  task automatic wait_fail(input int n);
    if (n >= 100) begin
      err_total++;
      $display("mismatch bus_wait expected answer seen none");
      results();
    end
  endtask : wait_fail

  // write word, both channels offered together
  task automatic axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    awaddr  <= {20'h0, a};
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    rs = bresp;
    bready <= 1'b0;
    wait_fail(n);
    @(posedge clk);
  endtask : axw

  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    araddr  <= {20'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    wait_fail(n);
    @(posedge clk);
  endtask : axr

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    axr(a, d, r);
    chk(nm, e, d);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    axw(a, v, r);
    chk("bresp", 32'h0, {30'h0, r});
  endtask : wr

  // pulse counters and transmit parity watch
  always @(posedge clk) begin
    if (err_msg_valid === 1'b1) begin
      n_msg++;
      last_sev = err_msg_sev;
    end
    if (irq_req === 1'b1) n_irq++;
    if (queue_discard === 1'b1) n_disc++;
    if (tx_valid === 1'b1) begin
      n_tx++;
      if (tx_eop === 1'b1) n_eop++;
      if (tx_sop === 1'b1) bad_pkt = exp_inj && (tx_data[31:24] == exp_len);
      chk("tx_par", {28'h0, bad_pkt ? ~ep(tx_data) : ep(tx_data)}, {28'h0, tx_par});
    end
  end

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd("ctl", 12'h4d4, 32'h0);
    rd("sts", 12'h4d8, 32'h0);
    rd("rep", 12'h4dc, 32'h2);
    rd("cnt", 12'h4e0, 32'h0);
    rd("toc", 12'h4e4, 32'h1);
    chk("to_en", 32'h1, {31'h0, to_en});
    axr(12'h4f0, d, r);
    chk("rresp_unmapped", 32'h2, {30'h0, r});
    axw(12'h4f0, 32'h1, r);
    chk("bresp_unmapped", 32'h2, {30'h0, r});
    $display("test reset done");
    i_pierc_core_model.send_rx(4, 1'b0);
    repeat (3) @(posedge clk);
    chk("msg_good", 32'h0, 32'(n_msg));
    i_pierc_core_model.send_rx(1, 1'b1);
    repeat (3) @(posedge clk);
    chk("msg", 32'h1, 32'(n_msg));
    chk("sev", 32'h2, {30'h0, last_sev});
    rd("sts", 12'h4d8, 32'h1);
    i_pierc_core_model.send_rx(2, 1'b1);
    repeat (3) @(posedge clk);
    chk("msg_again", 32'h1, 32'(n_msg));
    chk("irq_off", 32'h0, 32'(n_irq));
    rd("cnt", 12'h4e0, 32'h3);
    rd("cnt_cleared", 12'h4e0, 32'h0);
    wr(12'h4d8, 32'h0);
    rd("sts_w0", 12'h4d8, 32'h1);
    wr(12'h4d8, 32'h1);
    rd("sts_w1", 12'h4d8, 32'h0);
    $display("test detect done");
    for (int s = 0; s < 4; s++) begin
      up_irq <= s[0];
      wr(12'h4dc, 32'(s) | ((s >= 2) ? 32'h4 : 32'h0));
      wr(12'h4d8, 32'h1);
      m = n_msg;
      q = n_irq;
      i_pierc_core_model.send_rx(1, 1'b1);
      repeat (3) @(posedge clk);
      chk("msg_sev", 32'(s != 0), 32'(n_msg - m));
      if (s != 0) chk("sev", 32'(s), {30'h0, last_sev});
      chk("irq", 32'(s == 3), 32'(n_irq - q));
    end
    $display("test severity done");
    wr(12'h4d4, 32'h1);
    wr(12'h4d8, 32'h1);
    axr(12'h4e0, d, r);
    m = n_msg;
    q = n_irq;
    i_pierc_core_model.send_rx(3, 1'b1);
    repeat (3) @(posedge clk);
    rd("sts_dis", 12'h4d8, 32'h0);
    rd("cnt_dis", 12'h4e0, 32'h0);
    chk("msg_dis", 32'(m), 32'(n_msg));
    chk("irq_dis", 32'(q), 32'(n_irq));
    wr(12'h4d4, 32'h0);
    i_pierc_core_model.send_rx(260, 1'b1);
    repeat (3) @(posedge clk);
    rd("cnt_sat", 12'h4e0, 32'hff);
    $display("test disable and saturate done");
    wr(12'h4d4, 32'hffff_0502);
    rd("ctl_rsvd", 12'h4d4, 32'h0000_0502);
    exp_len = 8'h05;
    exp_inj = 1'b1;
    i_pierc_core_model.send_tlp(8'h05, 3);
    @(posedge clk);
    i_pierc_core_model.send_tlp(8'h06, 2);
    @(posedge clk);
    // lane 0 only: inject off, match length kept
    strb <= 4'h1;
    wr(12'h4d4, 32'h0000_ff00);
    strb <= 4'hf;
    rd("ctl_lane", 12'h4d4, 32'h0000_0500);
    exp_inj = 1'b0;
    i_pierc_core_model.send_tlp(8'h05, 2);
    repeat (2) @(posedge clk);
    chk("tx_dwords", 32'h7, 32'(n_tx));
    chk("tx_eops", 32'h3, 32'(n_eop));
    $display("test transmit done");
    expired <= 1'b1;
    @(posedge clk);
    expired <= 1'b0;
    repeat (3) @(posedge clk);
    chk("discard", 32'h1, 32'(n_disc));
    wr(12'h4e4, 32'h0);
    chk("to_en_off", 32'h0, {31'h0, to_en});
    expired <= 1'b1;
    @(posedge clk);
    expired <= 1'b0;
    repeat (3) @(posedge clk);
    chk("discard_off", 32'h1, 32'(n_disc));
    $display("test timeout done");
    results();
  end
endmodule : pierc_top_tb
